/* efc_flow_classifier.sv */
// Per-flow Ethernet header classifier with APB-mapped flow configuration.
// Assumes parsed headers arrive one per cycle from logic on CORE_CLK.
`timescale 1ns/100ps

module efc_flow_classifier #(
    parameter int NUM_FLOWS  = 8,
    parameter int NUM_CH     = 2,
    parameter bit FIRST_CMP  = 1'b1,
    parameter bit OAM_ENGINE = 1'b1
) (
    input  wire logic                 CORE_CLK,
    input  wire logic                 SYS_RST,
    input  wire logic                 PSEL,
    input  wire logic                 PENABLE,
    input  wire logic                 PWRITE,
    input  wire logic [11:0]          PADDR,
    input  wire logic [31:0]          PWDATA,
    output logic      [31:0]          PRDATA,
    output logic                      PREADY,
    output logic                      PSLVERR,
    input  wire logic                 HDR_VALID,
    input  wire efc_pkg::efc_hdr_type HDR,
    output logic                      MATCH_VALID,
    output logic      [NUM_FLOWS-1:0] MATCH_A,
    output logic      [NUM_FLOWS-1:0] MATCH_B
);

    // ------------------------------------------------------------------
    // Parameter checks
    // ------------------------------------------------------------------
    if (NUM_FLOWS < 1 || NUM_FLOWS > 8)
        $error("NUM_FLOWS must lie in 1..8");
    if (NUM_CH < 1 || NUM_CH > 8)
        $error("NUM_CH must lie in 1..8");

    // ------------------------------------------------------------------
    // Helper functions
    // ------------------------------------------------------------------
    function automatic logic tag_ok(input logic [11:0] vid, input logic [31:0] w);
        return ((vid ^ w[efc_pkg::VAL_LSB +: 12]) & w[efc_pkg::CARE_LSB +: 12]) == 12'h000;
    endfunction : tag_ok

    function automatic logic in_range(input logic [11:0] vid, input logic [31:0] w);
        return vid >= w[efc_pkg::VAL_LSB +: 12] && vid <= w[efc_pkg::CARE_LSB +: 12];
    endfunction : in_range

    function automatic logic mac_ok(input logic [47:0] a, input logic [47:0] m,
                                    input logic [2:0] kind);
        // No kind bit set means the address is not examined at all.
        return (kind == 3'h0) || (kind[0] && a == m)
            || (kind[1] && !a[47]) || (kind[2] && a[47]);
    endfunction : mac_ok

    function automatic logic flow_hit(input logic [31:0] cfg, input logic [31:0] mlo,
                                      input logic [31:0] mhi, input logic [31:0] t1,
                                      input logic [31:0] t2, input logic [31:0] rng,
                                      input efc_pkg::efc_hdr_type h,
                                      input logic [15:0] tpid, input logic pbb);
        logic        chk;
        logic        tags;
        logic        vals;
        logic        ft;
        logic        adr;
        logic [1:0]  cnt;
        logic [15:0] e1;
        logic [15:0] e2;
        logic [47:0] mac;
        chk  = cfg[efc_pkg::CFG_CHK_BIT];
        cnt  = cfg[efc_pkg::CFG_CNT_LSB +: 2];
        mac  = {mhi[15:0], mlo};
        e1   = cfg[efc_pkg::CFG_T1_BIT] ? tpid : efc_pkg::CTAG_TPID;
        e2   = cfg[efc_pkg::CFG_T2_BIT] ? tpid : efc_pkg::CTAG_TPID;
        vals = 1'b1;
        if (pbb)
        begin
            // The I-tag identifier is always checked, even with checking off.
            tags = h.itag_seen && h.isid == {rng[efc_pkg::CARE_LSB +: 12],
                                             rng[efc_pkg::VAL_LSB +: 12]};
            if (cfg[efc_pkg::CFG_T1_BIT])
                tags = tags && h.vlan_cnt == 2'h0;
            else
            begin
                tags = tags && h.vlan_cnt == 2'h1 && (!chk || h.tpid1 == tpid);
                vals = !chk || tag_ok(h.vid1, t1);
            end
        end
        else
        begin
            tags = h.vlan_cnt == cnt;
            if (chk && cnt != 2'h0)
                vals = h.tpid1 == e1 && tag_ok(h.vid1, t1);
            if (chk && cnt == 2'h2)
                vals = vals && h.tpid2 == e2 && tag_ok(h.vid2, t2);
            unique case (efc_pkg::efc_rng_type'(cfg[efc_pkg::CFG_RNG_LSB +: 2]))
                efc_pkg::EFC_RNG_TAG1: vals = vals && in_range(h.vid1, rng);
                efc_pkg::EFC_RNG_TAG2: vals = vals && in_range(h.vid2, rng);
                default:               vals = vals;
            endcase
        end
        if (h.len_type < efc_pkg::LEN_LIMIT)
            ft = cfg[efc_pkg::CFG_FT_BIT] && h.llc_snap;
        else
            ft = !h.llc_snap;
        unique case (efc_pkg::efc_msel_type'(cfg[efc_pkg::CFG_MSEL_LSB +: 2]))
            efc_pkg::EFC_MAC_DST: adr = mac_ok(h.da, mac, cfg[efc_pkg::CFG_KIND_LSB +: 3]);
            efc_pkg::EFC_MAC_SRC: adr = mac_ok(h.sa, mac, cfg[efc_pkg::CFG_KIND_LSB +: 3]);
            efc_pkg::EFC_MAC_ANY: adr = mac_ok(h.da, mac, cfg[efc_pkg::CFG_KIND_LSB +: 3])
                                     || mac_ok(h.sa, mac, cfg[efc_pkg::CFG_KIND_LSB +: 3]);
            default:              adr = 1'b0;
        endcase
        return cfg[efc_pkg::CFG_EN_BIT] && cfg[efc_pkg::CFG_CH_LSB + int'(h.channel)]
            && tags && vals && ft && adr;
    endfunction : flow_hit

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    logic [31:0]          regs_r   [NUM_FLOWS][efc_pkg::NUM_WORDS];
    logic [31:0]          regs_nxt [NUM_FLOWS][efc_pkg::NUM_WORDS];
    logic [31:0]          glb_r;
    logic [31:0]          glb_nxt;
    logic [7:0]           last_r;
    logic [7:0]           last_nxt;
    logic [15:0]          frames_r;
    logic [15:0]          frames_nxt;
    logic [31:0]          prdata_r;
    logic [31:0]          prdata_nxt;
    logic                 pready_r;
    logic                 pready_nxt;
    logic                 pslverr_r;
    logic                 pslverr_nxt;
    logic                 mvalid_r;
    logic                 mvalid_nxt;
    logic [NUM_FLOWS-1:0] ma_r;
    logic [NUM_FLOWS-1:0] ma_nxt;
    logic [NUM_FLOWS-1:0] mb_r;
    logic [NUM_FLOWS-1:0] mb_nxt;

    // ------------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------------
    always_comb
    begin
        logic [11:0]          foff;
        logic [NUM_FLOWS-1:0] hit;
        logic [NUM_FLOWS-1:0] grp;
        logic [31:0]          wmask;
        logic                 mapped;
        logic                 pbb;
        foff        = PADDR - efc_pkg::FLOW_BASE;
        hit         = '0;
        grp         = '0;
        wmask       = 32'h00000000;
        mapped      = 1'b0;
        regs_nxt    = regs_r;
        glb_nxt     = glb_r;
        last_nxt    = last_r;
        frames_nxt  = frames_r;
        prdata_nxt  = prdata_r;
        pslverr_nxt = 1'b0;
        // The access phase always lasts two cycles: pready rises one edge late.
        pready_nxt  = PSEL && PENABLE && !pready_r;
        // Only the first comparator owns a PBB enable; elsewhere the bit is stored and reads back but is ignored.
        pbb         = FIRST_CMP && glb_r[efc_pkg::GLB_PBB_BIT];
        if (PADDR == efc_pkg::GLB_OFS || PADDR == efc_pkg::STAT_OFS)
            mapped = 1'b1;
        for (int f = 0; f < NUM_FLOWS; f++)
            for (int w = 0; w < efc_pkg::NUM_WORDS; w++)
                if (PADDR >= efc_pkg::FLOW_BASE && PADDR[1:0] == 2'h0
                    && foff[11:efc_pkg::FLOW_SHIFT] == 7'(f) && foff[4:2] == 3'(w))
                begin
                    mapped = 1'b1;
                    if (pready_nxt && !PWRITE)
                        prdata_nxt = regs_r[f][w];
                    if (pready_r && PWRITE)
                    begin
                        unique case (3'(w))
                            efc_pkg::W_CFG:    wmask = efc_pkg::CFG_MASK;
                            efc_pkg::W_MAC_LO: wmask = efc_pkg::MACLO_MASK;
                            efc_pkg::W_MAC_HI: wmask = efc_pkg::MACHI_MASK;
                            default:           wmask = efc_pkg::TAG_MASK;
                        endcase
                        regs_nxt[f][w] = PWDATA & wmask;
                    end
                end
        if (pready_nxt)
        begin
            pslverr_nxt = !mapped;
            if (!mapped || PWRITE)
                prdata_nxt = 32'h00000000;
            else if (PADDR == efc_pkg::GLB_OFS)
                prdata_nxt = glb_r;
            else if (PADDR == efc_pkg::STAT_OFS)
                prdata_nxt = {frames_r, 8'h00, last_r};
        end
        if (pready_r && PWRITE && PADDR == efc_pkg::GLB_OFS)
            glb_nxt = PWDATA & efc_pkg::GLB_MASK;
        for (int f = 0; f < NUM_FLOWS; f++)
        begin
            hit[f] = flow_hit(regs_r[f][0], regs_r[f][1], regs_r[f][2], regs_r[f][3],
                              regs_r[f][4], regs_r[f][5], HDR, glb_r[15:0], pbb);
            grp[f] = OAM_ENGINE && regs_r[f][0][efc_pkg::CFG_GRP_BIT];
        end
        // Channels beyond the configured count never match.
        if (int'(HDR.channel) >= NUM_CH)
            hit = '0;
        mvalid_nxt = HDR_VALID;
        ma_nxt     = HDR_VALID ? (hit & ~grp) : '0;
        mb_nxt     = HDR_VALID ? (hit & grp) : '0;
        if (HDR_VALID)
        begin
            last_nxt   = 8'(hit);
            frames_nxt = frames_r + 16'h0001;
        end
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    always_ff @(posedge CORE_CLK)
    begin
        if (SYS_RST)
        begin
            for (int f = 0; f < NUM_FLOWS; f++)
                for (int w = 0; w < efc_pkg::NUM_WORDS; w++)
                    regs_r[f][w] <= efc_pkg::WORD_RST;
            glb_r     <= efc_pkg::GLB_RST;
            last_r    <= 8'h00;
            frames_r  <= 16'h0000;
            prdata_r  <= 32'h00000000;
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
            mvalid_r  <= 1'b0;
            ma_r      <= '0;
            mb_r      <= '0;
        end
        else
        begin
            regs_r    <= regs_nxt;
            glb_r     <= glb_nxt;
            last_r    <= last_nxt;
            frames_r  <= frames_nxt;
            prdata_r  <= prdata_nxt;
            pready_r  <= pready_nxt;
            pslverr_r <= pslverr_nxt;
            mvalid_r  <= mvalid_nxt;
            ma_r      <= ma_nxt;
            mb_r      <= mb_nxt;
        end
    end

    assign PRDATA      = prdata_r;
    assign PREADY      = pready_r;
    assign PSLVERR     = pslverr_r;
    assign MATCH_VALID = mvalid_r;
    assign MATCH_A     = ma_r;
    assign MATCH_B     = mb_r;

    // ------------------------------------------------------------------
    // Assertions on flow 0 and on the APB access phase
    // ------------------------------------------------------------------
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (SYS_RST);

    logic [31:0] c0;
    assign c0 = regs_r[0][0];

    sequence s_frame;
        HDR_VALID ##1 MATCH_VALID;
    endsequence

    sequence s_no_hit0;
        !MATCH_A[0] && !MATCH_B[0];
    endsequence

    property p_flow_off;
        (HDR_VALID && !c0[efc_pkg::CFG_EN_BIT]) |-> s_frame ##0 s_no_hit0;
    endproperty
    a_flow_off: assert property (p_flow_off) else $error("disabled flow matched");

    property p_chan_off;
        (HDR_VALID && !c0[efc_pkg::CFG_CH_LSB + int'(HDR.channel)]) |=> s_no_hit0;
    endproperty
    a_chan_off: assert property (p_chan_off) else $error("unused channel matched");

    function automatic logic pbb_on();
        return FIRST_CMP && glb_r[efc_pkg::GLB_PBB_BIT];
    endfunction : pbb_on

    property p_count;
        (HDR_VALID && !pbb_on() && HDR.vlan_cnt != c0[efc_pkg::CFG_CNT_LSB +: 2])
            |=> s_no_hit0;
    endproperty
    a_count: assert property (p_count) else $error("tag count mismatch matched");

    property p_ctag;
        (HDR_VALID && !pbb_on() && c0[efc_pkg::CFG_CHK_BIT] && !c0[efc_pkg::CFG_T1_BIT]
            && HDR.vlan_cnt != 2'h0 && HDR.tpid1 != 16'h8100) |=> s_no_hit0;
    endproperty
    a_ctag: assert property (p_ctag) else $error("wrong C-tag TPID matched");

    property p_stag2;
        (HDR_VALID && !pbb_on() && c0[efc_pkg::CFG_CHK_BIT] && c0[efc_pkg::CFG_T2_BIT]
            && HDR.vlan_cnt == 2'h2 && HDR.tpid2 != glb_r[15:0]) |=> s_no_hit0;
    endproperty
    a_stag2: assert property (p_stag2) else $error("wrong second tag TPID matched");

    property p_type2_only;
        (HDR_VALID && !c0[efc_pkg::CFG_FT_BIT] && HDR.len_type < 16'h0600) |=> s_no_hit0;
    endproperty
    a_type2_only: assert property (p_type2_only) else $error("length frame matched");

    property p_llc;
        (HDR_VALID && HDR.len_type < 16'h0600 && !HDR.llc_snap) |=> s_no_hit0;
    endproperty
    a_llc: assert property (p_llc) else $error("length frame without LLC/SNAP matched");

    property p_mcast_only;
        (HDR_VALID && c0[efc_pkg::CFG_MSEL_LSB +: 2] == 2'h0
            && c0[efc_pkg::CFG_KIND_LSB +: 3] == 3'h4 && !HDR.da[47]) |=> s_no_hit0;
    endproperty
    a_mcast_only: assert property (p_mcast_only) else $error("unicast matched multicast");

    property p_range;
        (HDR_VALID && !pbb_on() && c0[efc_pkg::CFG_RNG_LSB +: 2] == 2'h1
            && (HDR.vid1 < regs_r[0][5][11:0] || HDR.vid1 > regs_r[0][5][27:16]))
            |=> s_no_hit0;
    endproperty
    a_range: assert property (p_range) else $error("out of range tag matched");

    property p_isid;
        (HDR_VALID && pbb_on() && HDR.isid != {regs_r[0][5][27:16], regs_r[0][5][11:0]})
            |=> s_no_hit0;
    endproperty
    a_isid: assert property (p_isid) else $error("wrong service identifier matched");

    property p_group;
        HDR_VALID |=> !(MATCH_A[0] && MATCH_B[0])
            && (!MATCH_B[0] || (OAM_ENGINE && $past(c0[efc_pkg::CFG_GRP_BIT])));
    endproperty
    a_group: assert property (p_group) else $error("flow sent to wrong group");

    property p_apb;
        (PSEL && PENABLE && !PREADY) |=> PREADY ##1 !PREADY;
    endproperty
    a_apb: assert property (p_apb) else $error("access phase length wrong");

endmodule : efc_flow_classifier

/* efc_pkg.sv */
// Constants, register map and carrier types of the Ethernet flow classifier.
// Assumes a single datapath clock and an APB register port with 32-bit data.
package efc_pkg;

    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam logic [11:0] GLB_OFS     = 12'h000;
    localparam logic [11:0] STAT_OFS    = 12'h004;
    localparam logic [11:0] FLOW_BASE   = 12'h100;
    localparam int          FLOW_SHIFT  = 5;
    localparam int          NUM_WORDS   = 6;
    localparam logic [2:0]  W_CFG       = 3'h0;
    localparam logic [2:0]  W_MAC_LO    = 3'h1;
    localparam logic [2:0]  W_MAC_HI    = 3'h2;
    localparam logic [2:0]  W_TAG1      = 3'h3;
    localparam logic [2:0]  W_TAG2      = 3'h4;
    localparam logic [2:0]  W_RANGE     = 3'h5;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int CFG_EN_BIT    = 0;
    localparam int CFG_CNT_LSB   = 1;
    localparam int CFG_T1_BIT    = 3;
    localparam int CFG_T2_BIT    = 4;
    localparam int CFG_FT_BIT    = 5;
    localparam int CFG_CHK_BIT   = 6;
    localparam int CFG_RNG_LSB   = 7;
    localparam int CFG_MSEL_LSB  = 9;
    localparam int CFG_KIND_LSB  = 11;
    localparam int CFG_GRP_BIT   = 14;
    localparam int CFG_CH_LSB    = 16;
    localparam int VAL_LSB       = 0;
    localparam int CARE_LSB      = 16;
    localparam int GLB_PBB_BIT   = 16;
    localparam int STAT_CNT_LSB  = 16;

    // ------------------------------------------------------------------
    // Writable bits, reset values and fixed codes
    // ------------------------------------------------------------------
    localparam logic [31:0] CFG_MASK   = 32'h00ff7fff;
    localparam logic [31:0] MACLO_MASK = 32'hffffffff;
    localparam logic [31:0] MACHI_MASK = 32'h0000ffff;
    localparam logic [31:0] TAG_MASK   = 32'h0fff0fff;
    localparam logic [31:0] GLB_MASK   = 32'h0001ffff;
    localparam logic [31:0] WORD_RST   = 32'h00000000;
    localparam logic [31:0] GLB_RST    = 32'h00000000;
    localparam logic [15:0] CTAG_TPID  = 16'h8100;
    localparam logic [15:0] LEN_LIMIT  = 16'h0600;

    typedef enum logic [1:0] {
        EFC_RNG_NONE = 2'b00,
        EFC_RNG_TAG1 = 2'b01,
        EFC_RNG_TAG2 = 2'b10
    } efc_rng_type;

    typedef enum logic [1:0] {
        EFC_MAC_DST  = 2'b00,
        EFC_MAC_SRC  = 2'b01,
        EFC_MAC_ANY  = 2'b10,
        EFC_MAC_RSVD = 2'b11
    } efc_msel_type;

    // Parsed header fields of one frame, presented by the parser.
    typedef struct packed {
        logic [2:0]  channel;
        logic [47:0] da;
        logic [47:0] sa;
        logic [1:0]  vlan_cnt;
        logic [15:0] tpid1;
        logic [11:0] vid1;
        logic [15:0] tpid2;
        logic [11:0] vid2;
        logic        itag_seen;
        logic [23:0] isid;
        logic [15:0] len_type;
        logic        llc_snap;
    } efc_hdr_type;

endpackage : efc_pkg

/* efc_hdr_source.sv */
// Stand-in for the upstream parser: hands the classifier one parsed header.
// Assumes the bench calls send from its main sequence on CORE_CLK.
`timescale 1ns/100ps
module efc_hdr_source (
    input  wire logic            CORE_CLK,
    output logic                 HDR_VALID,
    output efc_pkg::efc_hdr_type HDR
);
    // ------------------------------------------------------------------
    // Header hand-over
    // ------------------------------------------------------------------
    initial
    begin
        HDR_VALID = 1'b0;
        HDR       = '0;
    end

    // Between frames the fields carry the inverse of the last header, so a
    // classifier that looks at them without the valid pulse is caught.
    task automatic send(input efc_pkg::efc_hdr_type h);
        @(posedge CORE_CLK);
        HDR_VALID <= 1'b1;
        HDR       <= h;
        @(posedge CORE_CLK);
        HDR_VALID <= 1'b0;
        HDR       <= ~h;
    endtask : send
endmodule : efc_hdr_source

/* efc_flow_classifier_bench.sv */
// Self-checking bench: flow setup over APB, then frames with expected hits.
// Assumes efc_pkg and the header source model are compiled first.
`timescale 1ns/100ps
`define CHK(nm, ex, got) \
    tests_run++; \
    if ((got) !== (ex)) \
    begin \
        $display("Error %s expected %h seen %h", nm, ex, got); \
        miscompares++; \
    end
module efc_flow_classifier_bench;
    localparam logic [47:0] DA = 48'h0a1122334455;
    localparam logic [47:0] MC = 48'h8a1122334455;
    localparam logic [47:0] SA = 48'h0c66778899aa;
    logic                 core_clk = 1'b0;
    logic                 sys_rst, psel, penable, pwrite, pready, pslverr, err;
    logic [11:0]          paddr;
    logic [31:0]          pwdata, prdata, rd;
    logic                 hdr_valid, match_valid;
    logic [7:0]           match_a, match_b;
    efc_pkg::efc_hdr_type hdr, base;
    int                   miscompares = 0;
    int                   tests_run = 0;

    always #5 core_clk = ~core_clk;

    efc_flow_classifier dut (.CORE_CLK(core_clk), .SYS_RST(sys_rst), .PSEL(psel),
        .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
        .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .HDR_VALID(hdr_valid),
        .HDR(hdr), .MATCH_VALID(match_valid), .MATCH_A(match_a), .MATCH_B(match_b));
    efc_hdr_source u_src (.CORE_CLK(core_clk), .HDR_VALID(hdr_valid), .HDR(hdr));

    // ------------------------------------------------------------------
    // Access tasks
    // ------------------------------------------------------------------
    task automatic complete_run();
        $display("Checks %0d, mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : complete_run

    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge core_clk);
        psel   <= 1'b1;
        pwrite <= wr;
        paddr  <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge core_clk);
            n++;
        end
        while (pready !== 1'b1 && n < 16);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1)
        begin
            miscompares++;
            complete_run();
        end
    endtask : apb

    task automatic rchk(input logic [11:0] a, input logic [31:0] ex);
        apb(1'b0, a, 32'h0);
        `CHK("prdata", ex, rd)
    endtask : rchk

    function automatic logic [11:0] fa(input int f, input logic [2:0] w);
        return efc_pkg::FLOW_BASE + 12'(f << efc_pkg::FLOW_SHIFT) + 12'({w, 2'b00});
    endfunction : fa

    // Enable and channel 0 use are always set, second-tag TPID select and other channels always clear; the rest comes from the call.
    function automatic logic [31:0] cw(input logic [1:0] cnt, input int t1,
        input int ft, input int chk, input logic [1:0] rng, input logic [1:0] ms,
        input logic [2:0] kd, input int grp);
        logic [31:0] w;
        w = 32'h00010001;
        w[efc_pkg::CFG_CNT_LSB +: 2] = cnt;
        w[efc_pkg::CFG_T1_BIT] = t1[0];
        w[efc_pkg::CFG_FT_BIT] = ft[0];
        w[efc_pkg::CFG_CHK_BIT] = chk[0];
        w[efc_pkg::CFG_RNG_LSB +: 2] = rng;
        w[efc_pkg::CFG_MSEL_LSB +: 2] = ms;
        w[efc_pkg::CFG_KIND_LSB +: 3] = kd;
        w[efc_pkg::CFG_GRP_BIT] = grp[0];
        return w;
    endfunction : cw

    task automatic mac(input logic [1:0] ms, input logic [2:0] kd, input logic [47:0] v);
        apb(1'b1, fa(0, efc_pkg::W_CFG), cw(2'd1, 0, 0, 0, 2'd0, ms, kd, 0));
        apb(1'b1, fa(0, efc_pkg::W_MAC_LO), v[31:0]);
        apb(1'b1, fa(0, efc_pkg::W_MAC_HI), {16'h0, v[47:32]});
    endtask : mac

    // The answer stands for one cycle right after the sampling edge.
    task automatic fr(input logic [11:0] vid, input logic [15:0] lt, input int llc,
        input logic [47:0] da, input logic [7:0] ea, input logic [7:0] eb);
        efc_pkg::efc_hdr_type h;
        h = base;
        h.vid1 = vid;
        h.len_type = lt;
        h.llc_snap = llc[0];
        h.da = da;
        u_src.send(h);
        #1;
        `CHK("match_valid", 1'b1, match_valid)
        `CHK("match_a", ea, match_a)
        `CHK("match_b", eb, match_b)
    endtask : fr

    // ------------------------------------------------------------------
    // Test sequence
    // ------------------------------------------------------------------
    initial
    begin
        sys_rst = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = '0;
        base = '0;
        base.da = DA;
        base.sa = SA;
        base.vlan_cnt = 2'd1;
        base.tpid1 = efc_pkg::CTAG_TPID;
        base.len_type = 16'h0800;
        repeat (6) @(posedge core_clk);
        sys_rst <= 1'b0;
        rchk(fa(0, efc_pkg::W_CFG), 32'h0);
        apb(1'b1, fa(3, efc_pkg::W_CFG), 32'hffffffff);
        rchk(fa(3, efc_pkg::W_CFG), efc_pkg::CFG_MASK);
        apb(1'b1, fa(3, efc_pkg::W_CFG), 32'h0);
        apb(1'b1, fa(3, efc_pkg::W_TAG1), 32'hffffffff);
        rchk(fa(3, efc_pkg::W_TAG1), efc_pkg::TAG_MASK);
        apb(1'b1, 12'h008, 32'h1);
        `CHK("pslverr", 1'b1, err)
        $display("Test registers done");
        apb(1'b1, fa(0, efc_pkg::W_CFG), cw(2'd1, 0, 0, 1, 2'd0, 2'd0, 3'd0, 0));
        apb(1'b1, fa(0, efc_pkg::W_TAG1), 32'h0fff0123);
        fr(12'h123, 16'h0800, 0, DA, 8'h01, 8'h00);
        fr(12'h124, 16'h0800, 0, DA, 8'h00, 8'h00);
        apb(1'b1, fa(7, efc_pkg::W_CFG), cw(2'd1, 0, 0, 1, 2'd0, 2'd0, 3'd0, 1));
        fr(12'h123, 16'h0800, 0, DA, 8'h01, 8'h80);
        apb(1'b1, fa(7, efc_pkg::W_CFG), 32'h0);
        base.channel = 3'd1;
        fr(12'h123, 16'h0800, 0, DA, 8'h00, 8'h00);
        base.channel = 3'd0;
        base.vlan_cnt = 2'd2;
        fr(12'h123, 16'h0800, 0, DA, 8'h00, 8'h00);
        base.vlan_cnt = 2'd1;
        apb(1'b1, efc_pkg::GLB_OFS, 32'h000088a8);
        rchk(efc_pkg::GLB_OFS, 32'h000088a8);
        base.tpid1 = 16'h88a8;
        fr(12'h123, 16'h0800, 0, DA, 8'h00, 8'h00);
        apb(1'b1, fa(0, efc_pkg::W_CFG), cw(2'd1, 1, 0, 1, 2'd0, 2'd0, 3'd0, 0));
        fr(12'h123, 16'h0800, 0, DA, 8'h01, 8'h00);
        base.tpid1 = efc_pkg::CTAG_TPID;
        fr(12'h123, 16'h0800, 0, DA, 8'h00, 8'h00);
        apb(1'b1, fa(0, efc_pkg::W_CFG), cw(2'd1, 0, 0, 1, 2'd0, 2'd0, 3'd0, 0));
        apb(1'b1, fa(0, efc_pkg::W_TAG1), 32'h00010123);
        fr(12'h455, 16'h0800, 0, DA, 8'h01, 8'h00);
        fr(12'h456, 16'h0800, 0, DA, 8'h00, 8'h00);
        $display("Test tags done");
        apb(1'b1, fa(0, efc_pkg::W_CFG), cw(2'd1, 0, 0, 0, 2'd1, 2'd0, 3'd0, 0));
        apb(1'b1, fa(0, efc_pkg::W_RANGE), 32'h0014000a);
        fr(12'h00a, 16'h0800, 0, DA, 8'h01, 8'h00);
        fr(12'h014, 16'h0800, 0, DA, 8'h01, 8'h00);
        fr(12'h009, 16'h0800, 0, DA, 8'h00, 8'h00);
        fr(12'h015, 16'h0800, 0, DA, 8'h00, 8'h00);
        $display("Test range done");
        apb(1'b1, fa(0, efc_pkg::W_CFG), cw(2'd1, 0, 0, 0, 2'd0, 2'd0, 3'd0, 0));
        fr(12'h123, 16'h0800, 0, DA, 8'h01, 8'h00);
        fr(12'h123, 16'h05ff, 1, DA, 8'h00, 8'h00);
        apb(1'b1, fa(0, efc_pkg::W_CFG), cw(2'd1, 0, 1, 0, 2'd0, 2'd0, 3'd0, 0));
        fr(12'h123, 16'h05ff, 1, DA, 8'h01, 8'h00);
        fr(12'h123, 16'h05ff, 0, DA, 8'h00, 8'h00);
        fr(12'h123, 16'h0600, 0, DA, 8'h01, 8'h00);
        fr(12'h123, 16'h0600, 1, DA, 8'h00, 8'h00);
        $display("Test frame type done");
        mac(2'd0, 3'd1, DA);
        fr(12'h123, 16'h0800, 0, DA, 8'h01, 8'h00);
        mac(2'd0, 3'd1, SA);
        fr(12'h123, 16'h0800, 0, DA, 8'h00, 8'h00);
        mac(2'd1, 3'd1, SA);
        fr(12'h123, 16'h0800, 0, DA, 8'h01, 8'h00);
        mac(2'd2, 3'd1, DA);
        fr(12'h123, 16'h0800, 0, DA, 8'h01, 8'h00);
        mac(2'd3, 3'd1, DA);
        fr(12'h123, 16'h0800, 0, DA, 8'h00, 8'h00);
        mac(2'd0, 3'd2, 48'h0);
        fr(12'h123, 16'h0800, 0, DA, 8'h01, 8'h00);
        fr(12'h123, 16'h0800, 0, MC, 8'h00, 8'h00);
        mac(2'd0, 3'd4, 48'h0);
        fr(12'h123, 16'h0800, 0, MC, 8'h01, 8'h00);
        fr(12'h123, 16'h0800, 0, DA, 8'h00, 8'h00);
        mac(2'd0, 3'd6, 48'h0);
        fr(12'h123, 16'h0800, 0, DA, 8'h01, 8'h00);
        $display("Test address done");
        base.vlan_cnt = 2'd2;
        base.tpid2 = 16'h88a8;
        base.vid2 = 12'h456;
        apb(1'b1, fa(0, efc_pkg::W_CFG), cw(2'd2, 0, 0, 1, 2'd0, 2'd0, 3'd0, 0) | 32'h10);
        apb(1'b1, fa(0, efc_pkg::W_TAG2), 32'h0fff0456);
        fr(12'h123, 16'h0800, 0, DA, 8'h01, 8'h00);
        base.tpid2 = efc_pkg::CTAG_TPID;
        fr(12'h123, 16'h0800, 0, DA, 8'h00, 8'h00);
        apb(1'b1, fa(0, efc_pkg::W_CFG), cw(2'd2, 0, 0, 0, 2'd2, 2'd0, 3'd0, 0));
        fr(12'h123, 16'h0800, 0, DA, 8'h00, 8'h00);
        apb(1'b1, fa(0, efc_pkg::W_TAG2), 32'h0);
        apb(1'b1, efc_pkg::GLB_OFS, 32'h000188a8);
        apb(1'b1, fa(0, efc_pkg::W_CFG), cw(2'd0, 1, 0, 0, 2'd0, 2'd0, 3'd0, 0));
        apb(1'b1, fa(0, efc_pkg::W_RANGE), 32'h01230456);
        base.vlan_cnt = 2'd0;
        base.itag_seen = 1'b1;
        base.isid = 24'h456123;
        fr(12'h123, 16'h0800, 0, DA, 8'h00, 8'h00);
        base.isid = 24'h123456;
        fr(12'h123, 16'h0800, 0, DA, 8'h01, 8'h00);
        base.itag_seen = 1'b0;
        fr(12'h123, 16'h0800, 0, DA, 8'h00, 8'h00);
        base.itag_seen = 1'b1;
        base.vlan_cnt = 2'd1;
        base.tpid1 = 16'h88a8;
        apb(1'b1, fa(0, efc_pkg::W_CFG), cw(2'd0, 0, 0, 1, 2'd0, 2'd0, 3'd0, 0));
        fr(12'h123, 16'h0800, 0, DA, 8'h01, 8'h00);
        apb(1'b1, fa(0, efc_pkg::W_CFG), cw(2'd0, 0, 0, 1, 2'd0, 2'd0, 3'd0, 0) & ~32'h1);
        fr(12'h123, 16'h0800, 0, DA, 8'h00, 8'h00);
        $display("Test backbone done");
        complete_run();
    end
endmodule : efc_flow_classifier_bench
